// ==== design/aisc_ctrl.sv ====
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// - conversion reference follows reference_select in control_c_reg
// - input and reference selections drive the analog side unbuffered
// - amplifier gain selectable from 1x to 16x, in every mode
// - amplifier disabled after reset, inputs sampled directly
// - amp_enable set to 1 with route field at ROUTE_AMP enables amplifier with gain field applied
// - amp route field is one storage shared by both input selects
// - power only needed modules, init in parallel, wait for slowest
// - init times: core 10 us, amplifier 20 us, references 60 us
// - temperature sensor or DAC input needs 35 us init
// - below 2 MHz peripheral clock core init is 20 clocks
// - low_latency keeps modules powered, no init delay per conversion
// - low latency still inits on first enable or init-needing change
// - init_busy_flag in status is high while init runs
// - direct sampling lasts sample_duration plus half converter clocks
// - amplifier samples continuously, holds only during converter readout
// - amp_readout_duration sets converter sampling length of amplifier
// - amplifier input sampling lasts at least sample_duration plus one
// - accumulation_count allows up to 1024 accumulated samples
// - converter clock is peripheral clock divided by control_b_reg prescaler
module aisc_ctrl
    import aisc_pkg::*;
#(
    parameter int PER_CLK_KHZ  = 100000,
    parameter int CORE_CLKS    = CORE_INIT_CLKS,
    parameter int AMP_CLKS     = AMP_INIT_CLKS,
    parameter int REF_CLKS     = REF_INIT_CLKS,
    parameter int INPUT_CLKS   = INPUT_INIT_CLKS
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // analog selection
    output logic [2:0]       ref_sel_o,
    output logic [5:0]       pos_mux_o,
    output logic [5:0]       neg_mux_o,
    output logic             amp_en_o,
    output logic [2:0]       amp_gain_o,
    // analog power and phase control
    output logic             core_pwr_o,
    output logic             amp_pwr_o,
    output logic             ref_pwr_o,
    output logic             adc_sample_o,
    output logic             amp_hold_o,
    output logic             conv_active_o,
    output logic             conv_done_o
);
    logic        enable_q, low_latency_q, freerun_q, series_q;
    logic [2:0]  presc_q, reference_select_q, gain_q;
    logic [7:0]  sample_duration_q, rdur_q;
    logic [3:0]  accum_q;
    logic [5:0]  pmux_q, nmux_q;
    logic [1:0]  route_q;
    logic        ampen_q, ready_q, warm_q, done_q;
    logic [31:0] rdata_q;
    logic [17:0] cnt_q, cnt_d, init_age_q;
    logic [10:0] scnt_q, scnt_d;
    aisc_state_t state_q, state_d;

    function automatic logic [17:0] phase_len(input logic [7:0] n, input logic [8:0] div,
                                              input logic half);
        logic [17:0] l;
        l = 18'(n) * 18'(div) + (half ? 18'(div >> 1) : 18'(div));
        return (l == 18'h0) ? 18'h1 : l;
    endfunction

    // bus decode
    wire         setup    = psel_i & ~penable_i;
    wire         wr       = psel_i & penable_i & pwrite_i;
    wire         mapped   = (paddr_i[1:0] == 2'h0) && (paddr_i <= OFS_STATUS);
    wire         wr_a     = wr & (paddr_i == OFS_CTRL_A);
    wire         wr_b     = wr & (paddr_i == OFS_CTRL_B);
    wire         wr_c     = wr & (paddr_i == OFS_CTRL_C);
    wire         wr_e     = wr & (paddr_i == OFS_CTRL_E);
    wire         wr_f     = wr & (paddr_i == OFS_CTRL_F);
    wire         wr_p     = wr & (paddr_i == OFS_POS_IN);
    wire         wr_n     = wr & (paddr_i == OFS_NEG_IN);
    wire         wr_amp   = wr & (paddr_i == OFS_AMP_CTRL);
    wire         wr_cmd   = wr & (paddr_i == OFS_COMMAND);
    wire         wr_st    = wr & (paddr_i == OFS_STATUS);
    wire [2:0]   gain_in  = pwdata_i[AMP_GAIN_LSB +: 3];
    wire [2:0]   gain_w   = (gain_in > GAIN_MAX) ? GAIN_MAX : gain_in;
    wire [3:0]   accum_w  = (pwdata_i[3:0] > ACCUM_MAX) ? ACCUM_MAX : pwdata_i[3:0];

    // configuration that needs initialization
    wire         amp_used = ampen_q & (route_q == ROUTE_AMP);
    wire         ref_int  = (reference_select_q != REF_VDD) && (reference_select_q != REF_EXT);
    wire         in_int   = (pmux_q == MUX_TEMP) || (pmux_q == MUX_DAC);
    wire [17:0]  core_len = (PER_CLK_KHZ < SLOW_PER_KHZ) ? 18'(SLOW_CORE_CLKS)
                                                         : 18'(CORE_CLKS);
    wire [17:0]  amp_len  = amp_used ? 18'(AMP_CLKS) : 18'h0;
    wire [17:0]  ref_len  = ref_int ? 18'(REF_CLKS) : 18'h0;
    wire [17:0]  in_len   = in_int ? 18'(INPUT_CLKS) : 18'h0;
    wire [17:0]  m1       = (core_len > amp_len) ? core_len : amp_len;
    wire [17:0]  m2       = (ref_len > in_len) ? ref_len : in_len;
    wire [17:0]  init_len = (m1 > m2) ? m1 : m2;

    // a write that moves the analog setup onto an init-needing choice
    wire [2:0]   ref_w    = pwdata_i[2:0];
    wire [5:0]   mux_w    = pwdata_i[5:0];
    wire         chg_ref  = wr_c && (ref_w != reference_select_q) && (ref_w != REF_VDD) && (ref_w != REF_EXT);
    wire         chg_mux  = wr_p && (mux_w != pmux_q) && ((mux_w == MUX_TEMP) || (mux_w == MUX_DAC));
    wire         chg_amp  = wr_amp && pwdata_i[AMP_EN_BIT] && !ampen_q;
    wire         chg_rt   = (wr_p | wr_n) && (pwdata_i[MUX_ROUTE_LSB +: 2] == ROUTE_AMP)
                            && (route_q != ROUTE_AMP);
    wire         cool     = !enable_q || !low_latency_q || chg_ref || chg_mux || chg_amp || chg_rt;

    // converter clock and phase lengths
    wire [8:0]   div      = 9'h2 << presc_q;
    wire [17:0]  samp_len = phase_len(sample_duration_q, div, !amp_used);
    wire [17:0]  rd_raw   = 18'(rdur_q) * 18'(div);
    wire [17:0]  rd_len   = (rd_raw == 18'h0) ? 18'h1 : rd_raw;
    wire [17:0]  conv_len = 18'(CONV_CLKS) * 18'(div);
    wire [10:0]  total    = 11'h1 << accum_q;

    wire         start    = wr_cmd & pwdata_i[CMD_START_BIT];
    wire         phase_end = (cnt_q == 18'h0);
    wire         last_smp = (scnt_q + 11'h1 >= total);
    wire         skip_init = low_latency_q & warm_q;
    wire         init_busy = (state_q == S_INIT);

    // sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = (cnt_q == 18'h0) ? 18'h0 : cnt_q - 18'h1;
        scnt_d  = scnt_q;
        unique case (state_q)
            S_IDLE: begin
                if (enable_q && start) begin
                    state_d = skip_init ? S_SAMP : S_INIT;
                    cnt_d   = (skip_init ? samp_len : init_len) - 18'h1;
                end
            end
            S_INIT: begin
                if (!enable_q) begin
                    state_d = S_IDLE;
                end else if (phase_end) begin
                    state_d = S_SAMP;
                    cnt_d   = samp_len - 18'h1;
                end
            end
            S_SAMP: begin
                if (!enable_q) begin
                    state_d = S_IDLE;
                end else if (phase_end) begin
                    state_d = amp_used ? S_ARD : S_CONV;
                    cnt_d   = (amp_used ? rd_len : conv_len) - 18'h1;
                end
            end
            S_ARD: begin
                if (!enable_q) begin
                    state_d = S_IDLE;
                end else if (phase_end) begin
                    state_d = S_CONV;
                    cnt_d   = conv_len - 18'h1;
                end
            end
            S_CONV: begin
                if (!enable_q) begin
                    state_d = S_IDLE;
                    scnt_d  = 11'h0;
                end else if (phase_end) begin
                    if (!last_smp) begin
                        scnt_d  = scnt_q + 11'h1;
                        state_d = series_q ? S_IDLE : S_SAMP;
                        cnt_d   = samp_len - 18'h1;
                    end else begin
                        scnt_d  = 11'h0;
                        state_d = freerun_q ? (skip_init ? S_SAMP : S_INIT) : S_IDLE;
                        cnt_d   = (skip_init ? samp_len : init_len) - 18'h1;
                    end
                end
            end
        endcase
    end

    wire conv_end = (state_q == S_CONV) && phase_end && enable_q && last_smp;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= S_IDLE;
            cnt_q   <= 18'h0;
            scnt_q  <= 11'h0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            scnt_q  <= scnt_d;
            done_q  <= conv_end;
        end
    end

    // warm after init while low latency holds; lost on init-needing change
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warm_q <= 1'b0;
        end else if (cool) begin
            warm_q <= 1'b0;
        end else if (init_busy && phase_end) begin
            warm_q <= 1'b1;
        end
    end

    // ready flag: the set wins over a write-one clear
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_q <= 1'b0;
        end else if (conv_end) begin
            ready_q <= 1'b1;
        end else if (wr_st && pwdata_i[ST_READY_BIT]) begin
            ready_q <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_q  <= 1'b0;
            low_latency_q  <= 1'b0;
            presc_q   <= RST_PRESC;
            reference_select_q  <= RST_REFERENCE_SELECT;
            sample_duration_q <= RST_SAMPLE_DURATION;
            accum_q   <= RST_ACCUM;
            freerun_q <= 1'b0;
            series_q  <= 1'b0;
            pmux_q    <= RST_MUX;
            nmux_q    <= RST_MUX;
            route_q   <= RST_ROUTE;
            ampen_q   <= 1'b0;
            gain_q    <= RST_GAIN;
            rdur_q    <= RST_RDUR;
        end else begin
            if (wr_a) begin
                enable_q <= pwdata_i[A_ENABLE_BIT];
                low_latency_q <= pwdata_i[A_LOW_LATENCY_BIT];
            end
            if (wr_b) presc_q <= pwdata_i[2:0];
            if (wr_c) reference_select_q <= ref_w;
            if (wr_e) sample_duration_q <= pwdata_i[7:0];
            if (wr_f) begin
                accum_q   <= accum_w;
                freerun_q <= pwdata_i[F_FREERUN_BIT];
                series_q  <= pwdata_i[F_SERIES_BIT];
            end
            if (wr_p) pmux_q <= mux_w;
            if (wr_n) nmux_q <= mux_w;
            if (wr_p || wr_n) route_q <= pwdata_i[MUX_ROUTE_LSB +: 2];
            if (wr_amp) begin
                ampen_q <= pwdata_i[AMP_EN_BIT];
                gain_q  <= gain_w;
                rdur_q  <= pwdata_i[AMP_RDUR_LSB +: 8];
            end
        end
    end

    // read data captured in the setup cycle
    wire [31:0] status_w = {13'h0, scnt_q, 5'h0, ready_q, (state_q != S_IDLE), init_busy};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr_i)
            OFS_CTRL_A:   rd_mux = {30'h0, low_latency_q, enable_q};
            OFS_CTRL_B:   rd_mux = {29'h0, presc_q};
            OFS_CTRL_C:   rd_mux = {29'h0, reference_select_q};
            OFS_CTRL_E:   rd_mux = {24'h0, sample_duration_q};
            OFS_CTRL_F:   rd_mux = {26'h0, series_q, freerun_q, accum_q};
            OFS_POS_IN:   rd_mux = {24'h0, route_q, pmux_q};
            OFS_NEG_IN:   rd_mux = {24'h0, route_q, nmux_q};
            OFS_AMP_CTRL: rd_mux = {16'h0, rdur_q, 4'h0, gain_q, ampen_q};
            OFS_STATUS:   rd_mux = status_w;
            default:      rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0;
        end else if (setup) begin
            rdata_q <= rd_mux;
        end
    end

    assign prdata_o  = rdata_q;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // analog side: selections straight from the registers
    wire active = (state_q != S_IDLE);
    wire held   = low_latency_q & enable_q & warm_q;
    assign ref_sel_o     = reference_select_q;
    assign pos_mux_o     = pmux_q;
    assign neg_mux_o     = nmux_q;
    assign amp_en_o      = amp_used;
    assign amp_gain_o    = gain_q;
    assign core_pwr_o    = active | held;
    assign amp_pwr_o     = (active | held) & amp_used;
    assign ref_pwr_o     = (active | held) & ref_int;
    assign adc_sample_o  = amp_used ? (state_q == S_ARD) : (state_q == S_SAMP);
    assign amp_hold_o    = amp_used & (state_q == S_ARD);
    assign conv_active_o = (state_q == S_CONV);
    assign conv_done_o   = done_q;

    // helper: cycles spent in init
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_age_q <= 18'h0;
        end else begin
            init_age_q <= init_busy ? init_age_q + 18'h1 : 18'h0;
        end
    end

    wire init_busy_next = (state_d == S_INIT);

    init_length_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        init_busy && !init_busy_next |-> (init_age_q + 18'h1 == init_len) || !enable_q)
        else $error("init phase length differs from slowest module");

    no_early_samp_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(state_q == S_SAMP) |-> $past(state_q) != S_INIT || $past(cnt_q) == 18'h0)
        else $error("sampling began before init finished");

    hold_only_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        amp_hold_o |-> state_q == S_ARD && amp_used && !conv_active_o)
        else $error("amplifier held outside readout");

    route_shared_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_n |=> route_q == $past(pwdata_i[MUX_ROUTE_LSB +: 2]))
        else $error("negative-side write did not update shared route");

    gain_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_amp && gain_in > GAIN_MAX |=> amp_gain_o == GAIN_MAX)
        else $error("gain beyond 16x was stored");

    low_latency_skip_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_q == S_IDLE && enable_q && start && low_latency_q && warm_q |=> state_q == S_SAMP)
        else $error("low latency start went through init");

    direct_samp_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(state_q == S_SAMP) && !amp_used |->
            cnt_q == 18'(sample_duration_q) * 18'(div) + 18'(div >> 1) - 18'h1 || sample_duration_q == 8'h0)
        else $error("direct sampling length wrong");

    amp_samp_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(state_q == S_SAMP) && amp_used |->
            cnt_q == (18'(sample_duration_q) + 18'h1) * 18'(div) - 18'h1)
        else $error("amplifier input sampling length wrong");

    busy_flag_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_q == S_IDLE && enable_q && start && !skip_init |=> status_w[ST_INIT_BIT] ##0
            !adc_sample_o)
        else $error("busy flag missing during init");

    reset_amp_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !ampen_q |-> !amp_en_o && !amp_pwr_o && !amp_hold_o)
        else $error("amplifier active while disabled");
endmodule

// ==== design/aisc_pkg.sv ====
package aisc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_A    = 8'h00;
    localparam logic [7:0] OFS_CTRL_B    = 8'h04;
    localparam logic [7:0] OFS_CTRL_C    = 8'h08;
    localparam logic [7:0] OFS_CTRL_E    = 8'h0c;
    localparam logic [7:0] OFS_CTRL_F    = 8'h10;
    localparam logic [7:0] OFS_POS_IN    = 8'h14;
    localparam logic [7:0] OFS_NEG_IN    = 8'h18;
    localparam logic [7:0] OFS_AMP_CTRL  = 8'h1c;
    localparam logic [7:0] OFS_COMMAND   = 8'h20;
    localparam logic [7:0] OFS_STATUS    = 8'h24;
    // field positions
    localparam int A_ENABLE_BIT   = 0;
    localparam int A_LOW_LATENCY_BIT   = 1;
    localparam int F_FREERUN_BIT  = 4;
    localparam int F_SERIES_BIT   = 5;
    localparam int MUX_ROUTE_LSB  = 6;
    localparam int AMP_EN_BIT     = 0;
    localparam int AMP_GAIN_LSB   = 1;
    localparam int AMP_RDUR_LSB   = 8;
    localparam int CMD_START_BIT  = 0;
    localparam int ST_INIT_BIT    = 0;
    localparam int ST_CONV_BIT    = 1;
    localparam int ST_READY_BIT   = 2;
    localparam int ST_COUNT_LSB   = 8;
    // reset values
    localparam logic [2:0] RST_PRESC    = 3'h0;
    localparam logic [2:0] RST_REFERENCE_SELECT   = 3'h0;
    localparam logic [7:0] RST_SAMPLE_DURATION  = 8'h00;
    localparam logic [3:0] RST_ACCUM    = 4'h0;
    localparam logic [5:0] RST_MUX      = 6'h00;
    localparam logic [1:0] RST_ROUTE    = 2'h0;
    localparam logic [2:0] RST_GAIN     = 3'h0;
    localparam logic [7:0] RST_RDUR     = 8'h00;
    // encodings
    localparam logic [2:0] REF_VDD      = 3'h0;
    localparam logic [2:0] REF_EXT      = 3'h2;
    localparam logic [5:0] MUX_TEMP     = 6'h31;
    localparam logic [5:0] MUX_DAC      = 6'h33;
    localparam logic [1:0] ROUTE_AMP    = 2'h1;
    localparam logic [2:0] GAIN_MAX     = 3'h4;
    localparam logic [3:0] ACCUM_MAX    = 4'ha;
    localparam logic [3:0] CONV_CLKS    = 4'hd;
    // timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CORE_INIT_NS    = 10000;
    localparam int AMP_INIT_NS     = 20000;
    localparam int REF_INIT_NS     = 60000;
    localparam int INPUT_INIT_NS   = 35000;
    localparam int SLOW_PER_KHZ    = 2000;
    localparam int SLOW_CORE_CLKS  = 20;
    localparam int CORE_INIT_CLKS  = (CORE_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AMP_INIT_CLKS   = (AMP_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_INIT_CLKS   = (REF_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INPUT_INIT_CLKS = (INPUT_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_INIT = 3'b001,
        S_SAMP = 3'b010,
        S_ARD  = 3'b011,
        S_CONV = 3'b100
    } aisc_state_t;
endpackage

// ==== sim/aisc_afe_model.sv ====
`timescale 1ns/100ps
// analog side: measures how long each phase signal stays high
module aisc_afe_model (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // phase controls from the block
    input  wire logic        pwr_i,
    input  wire logic        sample_i,
    input  wire logic        hold_i,
    input  wire logic        conv_i,
    // last lengths: powered wait, sample, hold, conversion
    output logic [15:0]      len_o [4],
    output logic [15:0]      conv_cnt_o
);
    logic [3:0]  phase;
    logic [15:0] cnt_q [4];

    // powered but idle of all phases counts as the wait before sampling
    assign phase = {conv_i, hold_i, sample_i, pwr_i & ~sample_i & ~hold_i & ~conv_i};

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= '0;
                len_o[i] <= '0;
            end
            conv_cnt_o <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (phase[i]) begin
                    cnt_q[i] <= cnt_q[i] + 16'h1;
                end else if (cnt_q[i] != 16'h0) begin
                    len_o[i] <= cnt_q[i];
                    cnt_q[i] <= '0;
                end
            end
            if (conv_i && cnt_q[3] == 16'h0) begin
                conv_cnt_o <= conv_cnt_o + 16'h1;
            end
        end
    end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/100ps
module tb
    import aisc_pkg::*;
;
    typedef struct {
        logic [2:0]  rf;
        logic [5:0]  mux;
        logic        amp;
        logic [7:0]  sd;
        logic [7:0]  rd;
        logic [15:0] pre;
        logic [15:0] smp;
    } aisc_row_t;
    logic        clock_i = 0;
    logic        rst_n_i = 0;
    logic        psel = 0;
    logic        pen = 0;
    logic        pwr = 0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic [2:0]  ref_sel, gain;
    logic [5:0]  pmux, nmux;
    logic        amp_en, cpw, apw, rpw, smp, hold, conv, done;
    logic [15:0] len [4];
    logic [15:0] ccnt, c0;
    int          err_total = 0;
    int          tests_run = 0;
    int          cyc = 0;
    aisc_row_t   rows [5] = '{
        '{3'h0, 6'h00, 1'b0, 8'h03, 8'h00, 16'h000a, 16'h0007},
        '{3'h1, 6'h00, 1'b0, 8'h00, 8'h00, 16'h003c, 16'h0001},
        '{3'h0, MUX_TEMP, 1'b0, 8'h02, 8'h00, 16'h0023, 16'h0005},
        '{3'h2, MUX_DAC, 1'b0, 8'h04, 8'h00, 16'h0023, 16'h0009},
        '{3'h2, 6'h00, 1'b1, 8'h02, 8'h03, 16'h001a, 16'h0006}};

    always #5 clock_i = ~clock_i;

    aisc_ctrl #(.CORE_CLKS(10), .AMP_CLKS(20), .REF_CLKS(60), .INPUT_CLKS(35)) u_aisc_ctrl (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .ref_sel_o(ref_sel), .pos_mux_o(pmux),
        .neg_mux_o(nmux), .amp_en_o(amp_en), .amp_gain_o(gain), .core_pwr_o(cpw),
        .amp_pwr_o(apw), .ref_pwr_o(rpw), .adc_sample_o(smp), .amp_hold_o(hold),
        .conv_active_o(conv), .conv_done_o(done));

    aisc_afe_model u_aisc_afe_model (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .pwr_i(cpw | apw | rpw), .sample_i(smp),
        .hold_i(hold), .conv_i(conv), .len_o(len), .conv_cnt_o(ccnt));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pen  <= 1'b0;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clock_i);
        pen <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) begin
            @(posedge clock_i);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        // let the write settle before callers look at outputs
        @(posedge clock_i);
    endtask

    task automatic run();
        int n;
        n = 0;
        apb(1, OFS_COMMAND, 32'h1);
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clock_i);
            n++;
        end
        check("done", {31'h0, done}, 32'h1);
        @(posedge clock_i);
    endtask

    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        apb(0, OFS_AMP_CTRL, 0);
        check("amp_ctrl rst", rd, 32'h0);
        check("amp_en rst", {31'h0, amp_en}, 32'h0);
        apb(1, OFS_CTRL_A, 32'h1);
        foreach (rows[i]) begin
            apb(1, OFS_CTRL_C, {29'h0, rows[i].rf});
            apb(1, OFS_CTRL_E, {24'h0, rows[i].sd});
            apb(1, OFS_POS_IN, {24'h0, 1'b0, rows[i].amp, rows[i].mux});
            apb(1, OFS_AMP_CTRL, {16'h0, rows[i].rd, 4'h0, rows[i].amp, 2'h0, rows[i].amp});
            check("ref", {29'h0, ref_sel}, {29'h0, rows[i].rf});
            check("mux", {26'h0, pmux}, {26'h0, rows[i].mux});
            check("amp_en", {31'h0, amp_en}, {31'h0, rows[i].amp});
            run();
            check("init", 32'(len[0]), 32'(rows[i].pre));
            check("sample len", 32'(len[1]), 32'(rows[i].smp));
            check("conv len", {16'h0, len[3]}, 32'h1a);
            if (rows[i].amp) check("hold len", 32'(len[2]), 32'(rows[i].smp));
        end
        check("gain", {29'h0, gain}, {29'h0, GAIN_MAX});
        apb(1, OFS_AMP_CTRL, 32'h2);
        check("gain low", {29'h0, gain}, 32'h1);
        apb(1, OFS_AMP_CTRL, 32'he);
        check("gain clamp", {29'h0, gain}, {29'h0, GAIN_MAX});
        apb(1, OFS_NEG_IN, 32'h0);
        apb(0, OFS_POS_IN, 0);
        check("shared route", rd & 32'hc0, 32'h0);
        apb(1, OFS_NEG_IN, 32'h45);
        check("neg mux", {26'h0, nmux}, 32'h5);
        apb(0, OFS_POS_IN, 0);
        check("shared route", rd & 32'hc0, 32'h40);
        apb(0, 8'h28, 0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped rd", rd, 32'h0);
        apb(1, OFS_POS_IN, 32'h0);
        apb(1, OFS_AMP_CTRL, 32'h0);
        apb(1, OFS_CTRL_C, 32'h0);
        apb(1, OFS_CTRL_A, 32'h3);
        apb(1, OFS_COMMAND, 32'h1);
        apb(0, OFS_STATUS, 0);
        check("init first", rd & 32'h1, 32'h1);
        run();
        apb(1, OFS_COMMAND, 32'h1);
        apb(0, OFS_STATUS, 0);
        check("warm start", rd & 32'h3, 32'h2);
        run();
        apb(1, OFS_CTRL_C, 32'h1);
        apb(1, OFS_COMMAND, 32'h1);
        apb(0, OFS_STATUS, 0);
        check("init on ref", rd & 32'h1, 32'h1);
        run();
        check("core pwr held", {31'h0, cpw}, 32'h1);
        check("ref pwr held", {31'h0, rpw}, 32'h1);
        check("amp pwr off", {31'h0, apw}, 32'h0);
        apb(1, OFS_CTRL_A, 32'h1);
        apb(1, OFS_CTRL_E, 32'hc);
        apb(1, OFS_CTRL_F, 32'h2);
        c0 = ccnt;
        run();
        check("accum count", {16'h0, ccnt - c0}, 32'h4);
        end_of_test();
    end
endmodule
